//--- core/nvmcsr_regs.v
// nvmcsr_regs.v: status, write lock, interrupt, data and
// address registers of the nonvolatile memory controller.
// assumes a wishbone classic master, one clock, and an
// nvm engine reporting busy levels and completion pulses.
//
// Operation
// - once the lock bit is one, every write to the application section is refused.
// - the lock bit can only be written to one, and only reset clears it.
// - the write fault bit reads one after a write error, including a protected write.
// - the write fault bit reflects only the latest completed operation.
// - the eeprom busy bit reads one while the eeprom executes a command.
// - the flash busy bit reads one while the flash executes a command.
// - writing one to the ready enable bit enables the ready interrupt, zero disables.
// - the ready interrupt is a level, held while enabled and the flag is set.
// - writing one to the ready flag clears it, writing zero leaves it; here a clear only sticks while the eeprom is busy.
// - when enabled with the eeprom idle, the interrupt is requested at once and again.
// - the data word has a low byte at its offset and high byte at offset plus one, reset zero.
// - the data word supplies fuse write data and the debug port can load it.
// - the address word has a low byte at its offset and high byte at offset plus one, reset zero.
// - the address word holds the address of the last location an operation updated.
// - the ready flag is set when the eeprom becomes ready for a new write or erase.
`timescale 1ns/1ns
`include "nvmcsr_map.vh"

module nvmcsr_regs #(
  parameter EVT_W = `NVMCSR_EVT_W
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // nvm engine status
  input wire flash_busy_i,
  input wire eeprom_busy_i,
  input wire op_done_i,
  input wire op_fault_i,
  input wire [15:0] op_addr_i,
  // application section write requests
  input wire app_wr_req_i,
  output wire app_wr_grant_o,
  output wire app_wr_refused_o,
  output wire app_section_write_lock_o,
  // debug port load of the data word
  input wire dbg_data_we_i,
  input wire [15:0] dbg_data_i,
  // register values towards the nvm engine
  output wire [15:0] data_word_o,
  output wire [15:0] address_word_o,
  // interrupt line
  output wire irq_o
);

  // =====================================================
  // functions

  // true when the address hits the given index with address bits 7:6 zero; byte lanes are not checked
  function hit;
    input [7:0] adr;
    input [3:0] idx;
    begin
      hit = (adr[7:6] == 2'h0) && (adr[5:2] == idx);
    end
  endfunction

  // place a byte into the low lane of a bus word
  function [31:0] lane0;
    input [7:0] b;
    begin
      lane0 = {24'h00_0000, b};
    end
  endfunction

  // =====================================================
  // declarations
  reg ack_ff;
  reg [31:0] rdat_ff;
  reg [31:0] nxt_rdat;
  reg lock_ff;
  reg fault_ff;
  reg flash_busy_ff;
  reg ee_busy_ff;
  reg ee_ready_en_ff;
  reg ee_ready_flag_ff;
  reg [15:0] data_ff;
  reg [15:0] addr_ff;
  reg [EVT_W-1:0] evt_ff;
  reg [EVT_W-1:0] evt_mask_ff;
  reg [EVT_W-1:0] nxt_evt;
  reg grant_ff;
  reg refused_ff;
  reg irq_ff;
  reg nxt_fault;
  reg nxt_flag;
  reg nxt_irq;
  wire req;
  wire wr_go;
  wire rd_go;
  wire wr_lo;
  wire [7:0] wb_byte;
  wire refuse;
  wire grant;
  wire fault_done;

  // =====================================================
  // bus handshake

  // request seen while no answer is pending
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;

  // side effects land on the edge where ack is sampled
  assign wr_go = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i;
  assign rd_go = wb_cyc_i & wb_stb_i & ack_ff & ~wb_we_i;

  // only byte lane 0 carries register bits
  assign wr_lo = wr_go & wb_sel_i[0];
  assign wb_byte = wb_dat_i[7:0];

  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // =====================================================
  // read mux, unmapped indices read zero

  always @* begin
    nxt_rdat = `NVMCSR_RST_DAT;
    if (wb_adr_i[7:6] == 2'h0) begin
      case (wb_adr_i[5:2])
        `NVMCSR_IDX_CTRL: begin
          nxt_rdat = lane0({7'h00, lock_ff});
        end
        `NVMCSR_IDX_STATUS: begin
          nxt_rdat = lane0({5'h00, fault_ff, ee_busy_ff, flash_busy_ff});
        end
        `NVMCSR_IDX_IRQ_EN: begin
          nxt_rdat = lane0({7'h00, ee_ready_en_ff});
        end
        `NVMCSR_IDX_IRQ_FLAG: begin
          nxt_rdat = lane0({7'h00, ee_ready_flag_ff});
        end
        `NVMCSR_IDX_DATA_LO: begin
          nxt_rdat = lane0(data_ff[7:0]);
        end
        `NVMCSR_IDX_DATA_HI: begin
          nxt_rdat = lane0(data_ff[15:8]);
        end
        `NVMCSR_IDX_ADDR_LO: begin
          nxt_rdat = lane0(addr_ff[7:0]);
        end
        `NVMCSR_IDX_ADDR_HI: begin
          nxt_rdat = lane0(addr_ff[15:8]);
        end
        `NVMCSR_IDX_EVT: begin
          nxt_rdat = {{(32-EVT_W){1'b0}}, evt_ff};
        end
        `NVMCSR_IDX_EVT_MASK: begin
          nxt_rdat = {{(32-EVT_W){1'b0}}, evt_mask_ff};
        end
        default: begin
          nxt_rdat = `NVMCSR_RST_DAT;
        end
      endcase
    end
  end

  // read data captured with the ack, held until next request
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= `NVMCSR_RST_DAT;
    end else if (req) begin
      rdat_ff <= nxt_rdat;
    end
  end

  // =====================================================
  // application section write lock

  // set only, a written zero is ignored
  always @(posedge clk_i) begin
    if (rst_i) begin
      lock_ff <= 1'b0;
    end else if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_CTRL) && wb_byte[`NVMCSR_CTRL_LOCK_BIT]) begin
      lock_ff <= 1'b1;
    end
  end

  // gate application writes with the lock
  assign refuse = app_wr_req_i & lock_ff;
  assign grant = app_wr_req_i & ~lock_ff;

  // one cycle grant or refusal per request
  always @(posedge clk_i) begin
    if (rst_i) begin
      grant_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      grant_ff <= grant;
      refused_ff <= refuse;
    end
  end

  // =====================================================
  // status bits

  // busy levels follow the engine, one cycle late
  always @(posedge clk_i) begin
    if (rst_i) begin
      flash_busy_ff <= 1'b0;
      ee_busy_ff <= 1'b0;
    end else begin
      flash_busy_ff <= flash_busy_i;
      ee_busy_ff <= eeprom_busy_i;
    end
  end

  // a refused write counts as a completed operation with error
  assign fault_done = op_done_i | refuse;

  // fault is rewritten by every completion, never accumulated
  always @* begin
    nxt_fault = fault_ff;
    if (fault_done) begin
      nxt_fault = refuse | op_fault_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  // =====================================================
  // eeprom ready interrupt

  // enable bit, plain read and write
  always @(posedge clk_i) begin
    if (rst_i) begin
      ee_ready_en_ff <= 1'b0;
    end else if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_IRQ_EN)) begin
      ee_ready_en_ff <= wb_byte[`NVMCSR_EEPROM_READY_IRQ_BIT];
    end
  end

  // flag re-sets while the eeprom is idle, so the set wins
  // over a write one clear; a clear only sticks while busy
  always @* begin
    nxt_flag = ee_ready_flag_ff;
    if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_IRQ_FLAG) && wb_byte[`NVMCSR_EEPROM_READY_IRQ_BIT]) begin
      nxt_flag = 1'b0;
    end
    if (!eeprom_busy_i) begin
      nxt_flag = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ee_ready_flag_ff <= 1'b0;
    end else begin
      ee_ready_flag_ff <= nxt_flag;
    end
  end

  // =====================================================
  // event status, cleared by read, set wins

  always @* begin
    nxt_evt = evt_ff;
    if (rd_go && hit(wb_adr_i, `NVMCSR_IDX_EVT)) begin
      nxt_evt = {EVT_W{1'b0}};
    end
    if (ee_busy_ff && !eeprom_busy_i) begin
      nxt_evt[`NVMCSR_EVT_READY_BIT] = 1'b1;
    end
    if (fault_done && nxt_fault) begin
      nxt_evt[`NVMCSR_EVT_FAULT_BIT] = 1'b1;
    end
    if (op_done_i) begin
      nxt_evt[`NVMCSR_EVT_DONE_BIT] = 1'b1;
    end
    if (refuse) begin
      nxt_evt[`NVMCSR_EVT_REFUSE_BIT] = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      evt_ff <= `NVMCSR_RST_EVT;
    end else begin
      evt_ff <= nxt_evt;
    end
  end

  // event mask, same layout
  always @(posedge clk_i) begin
    if (rst_i) begin
      evt_mask_ff <= `NVMCSR_RST_EVT;
    end else if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_EVT_MASK)) begin
      evt_mask_ff <= wb_byte[EVT_W-1:0];
    end
  end

  // =====================================================
  // interrupt output

  // computed from next state so the line is not a cycle stale
  always @* begin
    nxt_irq = (nxt_flag & ee_ready_en_ff) | (|(nxt_evt & evt_mask_ff));
    if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_IRQ_EN)) begin
      nxt_irq = (nxt_flag & wb_byte[`NVMCSR_EEPROM_READY_IRQ_BIT]) | (|(nxt_evt & evt_mask_ff));
    end
    if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_EVT_MASK)) begin
      nxt_irq = (nxt_flag & ee_ready_en_ff) | (|(nxt_evt & wb_byte[EVT_W-1:0]));
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // =====================================================
  // data word

  // debug port load beats a bus write in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_ff <= `NVMCSR_RST_WORD;
    end else if (dbg_data_we_i) begin
      data_ff <= dbg_data_i;
    end else if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_DATA_LO)) begin
      data_ff[7:0] <= wb_byte;
    end else if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_DATA_HI)) begin
      data_ff[15:8] <= wb_byte;
    end
  end

  // =====================================================
  // address word

  // a completing operation beats a bus write in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff <= `NVMCSR_RST_WORD;
    end else if (op_done_i) begin
      addr_ff <= op_addr_i;
    end else if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_ADDR_LO)) begin
      addr_ff[7:0] <= wb_byte;
    end else if (wr_lo && hit(wb_adr_i, `NVMCSR_IDX_ADDR_HI)) begin
      addr_ff[15:8] <= wb_byte;
    end
  end

  // =====================================================
  // outputs, all straight from flip-flops
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign app_wr_grant_o = grant_ff;
  assign app_wr_refused_o = refused_ff;
  assign app_section_write_lock_o = lock_ff;
  assign data_word_o = data_ff;
  assign address_word_o = addr_ff;
  assign irq_o = irq_ff;

endmodule

//--- core/nvmcsr_map.vh
// nvmcsr_map.vh: register map and field positions of the
// nonvolatile controller status and interrupt registers.
// assumes a word-indexed wishbone map, byte address = 4*index.
`ifndef NVMCSR_MAP_VH
`define NVMCSR_MAP_VH

// =====================================================
// register indices
`define NVMCSR_IDX_CTRL 4'h1
`define NVMCSR_IDX_STATUS 4'h2
`define NVMCSR_IDX_IRQ_EN 4'h3
`define NVMCSR_IDX_IRQ_FLAG 4'h4
`define NVMCSR_IDX_DATA_LO 4'h6
`define NVMCSR_IDX_DATA_HI 4'h7
`define NVMCSR_IDX_ADDR_LO 4'h8
`define NVMCSR_IDX_ADDR_HI 4'h9
`define NVMCSR_IDX_EVT 4'hA
`define NVMCSR_IDX_EVT_MASK 4'hB

// =====================================================
// field positions
`define NVMCSR_CTRL_LOCK_BIT 0
`define NVMCSR_ST_FLASH_BUSY_BIT 0
`define NVMCSR_ST_EE_BUSY_BIT 1
`define NVMCSR_ST_FAULT_BIT 2
`define NVMCSR_EEPROM_READY_IRQ_BIT 0
`define NVMCSR_EVT_READY_BIT 0
`define NVMCSR_EVT_FAULT_BIT 1
`define NVMCSR_EVT_DONE_BIT 2
`define NVMCSR_EVT_REFUSE_BIT 3

// =====================================================
// widths and reset values
`define NVMCSR_EVT_W 4
`define NVMCSR_RST_BYTE 8'h00
`define NVMCSR_RST_WORD 16'h0000
`define NVMCSR_RST_EVT 4'h0
`define NVMCSR_RST_DAT 32'h0000_0000

`endif

//--- testbench/nvmcsr_regs_asserts.sv
// nvmcsr_asserts: port-level properties of nvmcsr_regs.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
// ==========================================
// checker
module nvmcsr_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire app_wr_req_i,
  input wire app_wr_grant_o,
  input wire app_wr_refused_o,
  input wire app_section_write_lock_o,
  input wire op_done_i,
  input wire [15:0] op_addr_i,
  input wire dbg_data_we_i,
  input wire [15:0] dbg_data_i,
  input wire [15:0] data_word_o,
  input wire [15:0] address_word_o,
  input wire irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus answers one cycle after the request
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
  // engine requests: unlocked grants, locked refuses
  property p_grant;
    app_wr_req_i && !app_section_write_lock_o |=> app_wr_grant_o && !app_wr_refused_o;
  endproperty
  a_grant: assert property (p_grant) else $error("no grant");
  property p_refuse;
    app_wr_req_i && app_section_write_lock_o |=> app_wr_refused_o && !app_wr_grant_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("no refusal");
  // lock only clears by reset
  property p_lock_hold;
    app_section_write_lock_o |=> app_section_write_lock_o;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
  property p_lock_set;
    wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0] && wb_dat_i[0]
      |=> app_section_write_lock_o;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");
  property p_op_addr;
    op_done_i |=> address_word_o == $past(op_addr_i);
  endproperty
  a_op_addr: assert property (p_op_addr) else $error("address not taken");
  property p_dbg;
    dbg_data_we_i |=> data_word_o == $past(dbg_data_i);
  endproperty
  a_dbg: assert property (p_dbg) else $error("debug load lost");
  // reset clears the words and the request line
  property p_rst;
    disable iff (1'b0) rst_i |=> !irq_o && !app_section_write_lock_o && data_word_o == 16'h0000
      && address_word_o == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  c_refuse: cover property (app_wr_req_i && app_section_write_lock_o);
  c_dbg: cover property (dbg_data_we_i);
  c_irq: cover property ($rose(irq_o));
endmodule

bind nvmcsr_regs nvmcsr_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .app_wr_req_i(app_wr_req_i), .app_wr_grant_o(app_wr_grant_o), .app_wr_refused_o(app_wr_refused_o),
  .app_section_write_lock_o(app_section_write_lock_o), .op_done_i(op_done_i), .op_addr_i(op_addr_i),
  .dbg_data_we_i(dbg_data_we_i), .dbg_data_i(dbg_data_i), .data_word_o(data_word_o),
  .address_word_o(address_word_o), .irq_o(irq_o));

//--- testbench/tb_top.sv
// tb_top: random and directed bench for nvmcsr_regs.
// assumes ack within 20 cycles and a 125 MHz clock.
`timescale 1ns/1ns
// ==========================================
// bench
module tb_top;
  reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  reg fb = 0, eb = 0, od = 0, of = 0, rq = 0, dw = 0;
  reg [7:0] adr = 0;
  reg [3:0] sel = 0;
  reg [31:0] dat = 0, r;
  reg [15:0] oa = 0, dd = 0, d;
  wire [31:0] q;
  wire ack, g, rf, lk, irq;
  wire [15:0] dwo, awo;
  integer fails = 0, n_checks = 0, i;
  always #4 clk_i = ~clk_i;
  nvmcsr_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack), .flash_busy_i(fb),
    .eeprom_busy_i(eb), .op_done_i(od), .op_fault_i(of), .op_addr_i(oa), .app_wr_req_i(rq),
    .app_wr_grant_o(g), .app_wr_refused_o(rf), .app_section_write_lock_o(lk), .dbg_data_we_i(dw),
    .dbg_data_i(dd), .data_word_o(dwo), .address_word_o(awo), .irq_o(irq));
  // ==========================================
  // checking and closing
  task chk(input [31:0] gv, input [31:0] ev);
    begin
      n_checks = n_checks + 1;
      if (gv !== ev) begin
        fails = fails + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, gv, ev);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  // ==========================================
  // wishbone classic cycle, bounded wait for ack
  task bus(input w, input [3:0] x, input [7:0] v, input [3:0] s);
    integer k;
    begin
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= {2'b00, x, 2'b00};
      dat <= {24'h000000, v};
      sel <= s;
      k = 0;
      // ack and read data are sampled at the rising edge itself
      @(posedge clk_i);
      while (ack !== 1'b1 && k < 20) begin
        k = k + 1;
        @(posedge clk_i);
      end
      if (ack !== 1'b1) begin
        fails = fails + 1;
        tally_and_finish;
      end
      r = q;
      cyc <= 0;
      stb <= 0;
      @(posedge clk_i);
    end
  endtask
  // irq looked at mid-cycle, away from the edge that launches it
  task chk_irq(input e);
    begin
      @(negedge clk_i);
      chk({31'h0, irq}, {31'h0, e});
      @(posedge clk_i);
    end
  endtask
  task wr(input [3:0] x, input [7:0] v);
    bus(1'b1, x, v, 4'hF);
  endtask
  // read, mask, compare
  task rc(input [3:0] x, input [31:0] m, input [31:0] e);
    begin
      bus(1'b0, x, 8'h00, 4'hF);
      chk(r & m, e);
    end
  endtask
  // engine write request; pulse looked at in its one cycle
  task appreq(input l);
    begin
      rq <= 1;
      @(posedge clk_i);
      rq <= 0;
      @(negedge clk_i);
      chk({g, rf}, {!l, l});
      @(posedge clk_i);
    end
  endtask
  task op(input f, input [15:0] a);
    begin
      od <= 1;
      of <= f;
      oa <= a;
      @(posedge clk_i);
      od <= 0;
      @(posedge clk_i);
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    i = $urandom(74877);
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    // flag idx4 sets once idle, all else reads zero
    for (i = 0; i < 16; i = i + 1)
      rc(i[3:0], 32'hFFFFFFFF, {31'h0, i == 4});
    for (i = 0; i < 6; i = i + 1) begin
      d = (i == 0) ? 16'hFFFF : 16'($urandom);
      wr(4'h6, d[7:0]);
      wr(4'h7, d[15:8]);
      bus(1'b1, 4'h6, ~d[7:0], 4'h0);
      rc(4'h6, 32'hFF, {24'h0, d[7:0]});
      rc(4'h7, 32'hFF, {24'h0, d[15:8]});
      chk({16'h0, dwo}, {16'h0, d});
    end
    d = 16'($urandom);
    dw <= 1;
    dd <= d;
    @(posedge clk_i);
    dw <= 0;
    rc(4'h7, 32'hFF, {24'h0, d[15:8]});
    wr(4'h8, 8'hA5);
    wr(4'h9, 8'h3C);
    rc(4'h9, 32'hFF, 32'h3C);
    op(1'b1, d);
    rc(4'h8, 32'hFF, {24'h0, d[7:0]});
    rc(4'h9, 32'hFF, {24'h0, d[15:8]});
    chk({16'h0, awo}, {16'h0, d});
    rc(4'h2, 32'h4, 32'h4);
    op(1'b0, ~d);
    rc(4'h2, 32'h4, 32'h0);
    fb <= 1;
    eb <= 1;
    @(posedge clk_i);
    rc(4'h2, 32'hFF, 32'h3);
    fb <= 0;
    // while busy the flag only clears by a one
    wr(4'h4, 8'h00);
    rc(4'h4, 32'h1, 32'h1);
    wr(4'h4, 8'h01);
    rc(4'h4, 32'h1, 32'h0);
    wr(4'h3, 8'h01);
    rc(4'h3, 32'hFF, 32'h1);
    chk_irq(1'b0);
    eb <= 0;
    repeat (3) @(posedge clk_i);
    chk_irq(1'b1);
    wr(4'h4, 8'h01);
    rc(4'h4, 32'h1, 32'h1);
    chk_irq(1'b1);
    wr(4'h3, 8'h00);
    @(posedge clk_i);
    chk_irq(1'b0);
    appreq(1'b0);
    wr(4'h1, 8'h00);
    rc(4'h1, 32'hFF, 32'h0);
    wr(4'h1, 8'h01);
    rc(4'h1, 32'hFF, 32'h1);
    chk({31'h0, lk}, 32'h1);
    // ready, fault and done events gathered so far, no refusal yet
    rc(4'hA, 32'hF, 32'h7);
    wr(4'hB, 8'h08);
    appreq(1'b1);
    @(posedge clk_i);
    chk_irq(1'b1);
    rc(4'h2, 32'h4, 32'h4);
    rc(4'hA, 32'h8, 32'h8);
    @(posedge clk_i);
    chk_irq(1'b0);
    wr(4'h1, 8'h00);
    rc(4'h1, 32'hFF, 32'h1);
    tally_and_finish;
  end
endmodule
